// ===== spi_port_pkg.sv
// spi_port_pkg: register offsets, field layouts, reset values and engine states
// assumes: shared by the serial port control block, its checks and the bench; the byte fifo does not use it
`default_nettype none

package spi_port_pkg;

    // data path and fifo shape
    localparam int DATA_W     = 8;
    localparam int FIFO_DEPTH = 4;
    localparam int LEVEL_W    = 3;
    localparam int ADDR_W     = 5;
    localparam int CTRL_W     = 16;

    // register offsets
    localparam logic [ADDR_W-1:0] STATUS_OFS = 5'h00;
    localparam logic [ADDR_W-1:0] RX_OFS     = 5'h04;
    localparam logic [ADDR_W-1:0] TX_OFS     = 5'h08;
    localparam logic [ADDR_W-1:0] DIV_OFS    = 5'h0c;
    localparam logic [ADDR_W-1:0] CTRL_OFS   = 5'h10;

    // reset values
    localparam logic [CTRL_W-1:0] CTRL_RESET = 16'h0000;
    localparam logic [DATA_W-1:0] DIV_RESET  = 8'h00;
    localparam logic [DATA_W-1:0] ZERO_BYTE  = 8'h00;

    // one byte is sixteen clock edges, numbered 0 to 15
    localparam logic [3:0] PHASE_FIRST = 4'h0;
    localparam logic [3:0] PHASE_LAST  = 4'hf;

    // control register layout, bit 15 first
    typedef struct packed {
        logic [1:0] irq_threshold_field;
        logic       tx_fifo_flush;
        logic       rx_fifo_flush;
        logic       continuous_transfer_en;
        logic       loopback_en;
        logic       slave_miso_drive_en;
        logic       rx_overwrite_en;
        logic       zero_fill_en;
        logic       transfer_trigger_sel;
        logic       lsb_first_en;
        logic       wired_or_output_en;
        logic       clock_polarity;
        logic       clock_phase;
        logic       master_select;
        logic       port_enable;
    } ctrl_s;

    // status register layout, bit 15 first
    typedef struct packed {
        logic [3:0]         reserved;
        logic               rx_excess;
        logic [LEVEL_W-1:0] rx_level;
        logic               rx_overflow_flag;
        logic               rx_irq;
        logic               tx_irq;
        logic               tx_underflow_flag;
        logic [LEVEL_W-1:0] tx_level;
        logic               irq_pending;
    } status_s;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_RUN,
        ST_GAP
    } xfer_state_e;

endpackage : spi_port_pkg

`default_nettype wire

// ===== spi_port_control.sv
// spi_port_control: serial port engine with control, status, data and divider registers
// assumes: one clock domain on clk_in; serial pins arrive asynchronous and are synchronised
//
// Notes on behaviour
// - threshold field picks one to four shifted bytes before the transmit interrupt.
// - threshold field picks one to four held bytes for the receive interrupt.
// - transmit flush bit empties the transmit fifo while set; software clears it.
// - writes to transmit data are dropped while transmit flush is set.
// - held transmit flush sends last byte or zero per zero fill.
// - receive flush empties receive fifo, drops incoming bytes, raises no receive or overflow interrupts.
// - with receive flush and read trigger, a receive read still starts a transfer.
// - continuous master mode runs bytes back to back, select held until empty.
// - without continuous mode, one serial clock idle gap separates write-triggered frames.
// - loopback feeds the outgoing data bit back into the receiver.
// - slave output drive bit clear leaves the slave data output open drain.
// - on receive overflow, overwrite bit replaces oldest byte, else new byte dropped.
// - empty transmit fifo sends zero when zero fill set, else last byte.
// - trigger bit picks transmit write or receive read as transfer start.
// - lsb first bit selects shift direction of both data paths.
// - wired-or bit drives data outputs low only; pull-ups are external.
// - clock polarity bit sets the serial clock rest level.
// - clock phase bit moves data change to the leading clock edge.
// - master select bit makes the port generate the serial clock.
// - port enable clear stops and holds the engine idle.
// - byte arriving at full receive fifo sets overflow; status read clears it.
// - transfer start with empty transmit fifo sets underflow; status read clears it.
// - both fifos hold four bytes, levels reported as counts zero to four.
`default_nettype none

module spi_byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    // clock and reset
    input  wire logic                           clk_in,
    input  wire logic                           rst_n_in,
    // filling side
    input  wire logic                           in_valid_in,
    output logic                                in_ready_out,
    input  wire logic [WIDTH-1:0]               in_data_in,
    // draining side
    output logic                                out_valid_out,
    input  wire logic                           out_ready_in,
    output logic [WIDTH-1:0]                    out_data_out,
    // control and level
    input  wire logic                           flush_in,
    output logic [$clog2(DEPTH+1)-1:0]          level_out
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH+1);
    localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH-1);
    localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [PW-1:0]    wr_ptr_r, wr_ptr_nxt;
    logic [PW-1:0]    rd_ptr_r, rd_ptr_nxt;
    logic [CW-1:0]    count_r, count_nxt;
    logic             push, pop;

    assign out_valid_out = (count_r != '0);
    assign in_ready_out  = (count_r != CNT_FULL) || out_ready_in;
    assign out_data_out  = mem_r[rd_ptr_r];
    assign level_out     = count_r;

    always_comb begin
        push       = in_valid_in && in_ready_out && !flush_in;
        pop        = out_valid_out && out_ready_in && !flush_in;
        wr_ptr_nxt = wr_ptr_r;
        rd_ptr_nxt = rd_ptr_r;
        count_nxt  = count_r;
        if (flush_in) begin
            wr_ptr_nxt = '0;
            rd_ptr_nxt = '0;
            count_nxt  = '0;
        end else begin
            if (push) begin
                wr_ptr_nxt = (wr_ptr_r == PTR_LAST) ? '0 : wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_nxt = (rd_ptr_r == PTR_LAST) ? '0 : rd_ptr_r + 1'b1;
            end
            if (push && !pop) begin
                count_nxt = count_r + 1'b1;
            end else if (pop && !push) begin
                count_nxt = count_r - 1'b1;
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r  <= '0;
        end else begin
            wr_ptr_r <= wr_ptr_nxt;
            rd_ptr_r <= rd_ptr_nxt;
            count_r  <= count_nxt;
        end
    end

    // per-entry storage
    for (genvar i = 0; i < DEPTH; i++) begin : g_entry
        always_ff @(posedge clk_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
                mem_r[i] <= '0;
            end else if (push && (wr_ptr_r == PW'(i))) begin
                mem_r[i] <= in_data_in;
            end
        end
    end

endmodule : spi_byte_fifo

module spi_port_control
    import spi_port_pkg::*;
(
    // clock and reset
    input  wire logic               clk_in,
    input  wire logic               rst_n_in,
    // register port
    input  wire logic               reg_wr_in,
    input  wire logic               reg_rd_in,
    input  wire logic [ADDR_W-1:0]  reg_addr_in,
    input  wire logic [CTRL_W-1:0]  reg_wdata_in,
    output logic [CTRL_W-1:0]       reg_rdata_out,
    output logic                    tx_space_out,
    output logic                    irq_out,
    // serial clock pin
    input  wire logic               sclk_in,
    output logic                    sclk_out,
    output logic                    sclk_oe_out,
    // data pins
    input  wire logic               mosi_in,
    output logic                    mosi_out,
    output logic                    mosi_oe_out,
    input  wire logic               miso_in,
    output logic                    miso_out,
    output logic                    miso_oe_out,
    // chip select pins
    input  wire logic               chip_select_pin_n_in,
    output logic                    chip_select_pin_n_out
);
    ctrl_s              ctrl_r, ctrl_nxt;
    logic [DATA_W-1:0]  div_r, div_nxt;
    logic [CTRL_W-1:0]  rdata_r, rdata_nxt;
    logic               ovf_r, ovf_nxt, uf_r, uf_nxt;
    logic               rxirq_r, rxirq_nxt, txirq_r, txirq_nxt, isr_r, isr_nxt;

    xfer_state_e        state_r, state_nxt;
    logic [DATA_W-1:0]  div_cnt_r, div_cnt_nxt;
    logic [3:0]         phase_r, phase_nxt;
    logic [DATA_W-1:0]  tx_sh_r, tx_sh_nxt, rx_sh_r, rx_sh_nxt, last_tx_r, last_tx_nxt;
    logic               sclk_lvl_r, sclk_lvl_nxt, cs_act_r, cs_act_nxt;
    logic               out_bit_r, out_bit_nxt, start_pend_r, start_pend_nxt;
    logic [1:0]         tx_done_r, tx_done_nxt;
    logic               sclk_pin_r;

    logic               sclk_s1, sclk_s2, sclk_prev_r, mosi_s1, mosi_s2;
    logic               miso_s1, miso_s2, cs_s1, cs_s2;

    logic               tx_wr, rx_rd, st_rd;
    logic               tx_valid, tx_pop, rx_full, rx_push, rx_pop, rx_valid;
    logic [DATA_W-1:0]  tx_head, rx_head, rx_byte, load_byte, rx_ins;
    logic [LEVEL_W-1:0] tx_level, rx_level;
    logic               edge_ev, lead, sample, shift, load, byte_done, in_bit;
    logic               uf_set, ovf_set, rxirq_set, txirq_set, od_mode;
    status_s            status;

    // two-flop synchronisers on every serial input
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sclk_s1     <= 1'b0;
            sclk_s2     <= 1'b0;
            sclk_prev_r <= 1'b0;
            mosi_s1     <= 1'b0;
            mosi_s2     <= 1'b0;
            miso_s1     <= 1'b0;
            miso_s2     <= 1'b0;
            cs_s1       <= 1'b1;
            cs_s2       <= 1'b1;
        end else begin
            sclk_s1     <= sclk_in;
            sclk_s2     <= sclk_s1;
            sclk_prev_r <= sclk_s2;
            mosi_s1     <= mosi_in;
            mosi_s2     <= mosi_s1;
            miso_s1     <= miso_in;
            miso_s2     <= miso_s1;
            cs_s1       <= chip_select_pin_n_in;
            cs_s2       <= cs_s1;
        end
    end

    // fifos
    spi_byte_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
        .clk_in        (clk_in),
        .rst_n_in      (rst_n_in),
        .in_valid_in   (tx_wr && !ctrl_r.tx_fifo_flush),
        .in_ready_out  (tx_space_out),
        .in_data_in    (reg_wdata_in[DATA_W-1:0]),
        .out_valid_out (tx_valid),
        .out_ready_in  (tx_pop),
        .out_data_out  (tx_head),
        .flush_in      (ctrl_r.tx_fifo_flush),
        .level_out     (tx_level)
    );

    spi_byte_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
        .clk_in        (clk_in),
        .rst_n_in      (rst_n_in),
        .in_valid_in   (rx_push),
        .in_ready_out  (),
        .in_data_in    (rx_byte),
        .out_valid_out (rx_valid),
        .out_ready_in  (rx_pop),
        .out_data_out  (rx_head),
        .flush_in      (ctrl_r.rx_fifo_flush),
        .level_out     (rx_level)
    );

    assign tx_wr   = reg_wr_in && (reg_addr_in == TX_OFS);
    assign rx_rd   = reg_rd_in && (reg_addr_in == RX_OFS);
    assign st_rd   = reg_rd_in && (reg_addr_in == STATUS_OFS);
    assign rx_full = (rx_level == LEVEL_W'(FIFO_DEPTH));
    assign in_bit  = ctrl_r.loopback_en ? out_bit_r
                   : (ctrl_r.master_select ? miso_s2 : mosi_s2);

    // transfer engine
    always_comb begin
        state_nxt      = state_r;
        div_cnt_nxt    = div_cnt_r;
        phase_nxt      = phase_r;
        sclk_lvl_nxt   = sclk_lvl_r;
        cs_act_nxt     = cs_act_r;
        start_pend_nxt = start_pend_r;
        edge_ev        = 1'b0;
        load           = 1'b0;
        if (rx_rd && !ctrl_r.transfer_trigger_sel && ctrl_r.master_select) begin
            start_pend_nxt = 1'b1;
        end
        if (!ctrl_r.port_enable) begin
            state_nxt      = ST_IDLE;
            cs_act_nxt     = 1'b0;
            sclk_lvl_nxt   = 1'b0;
            start_pend_nxt = 1'b0;
            phase_nxt      = PHASE_FIRST;
        end else if (ctrl_r.master_select) begin
            case (state_r)
                ST_IDLE: begin
                    if (start_pend_r || (ctrl_r.transfer_trigger_sel && tx_valid)) begin
                        load           = 1'b1;
                        state_nxt      = ST_RUN;
                        cs_act_nxt     = 1'b1;
                        div_cnt_nxt    = div_r;
                        phase_nxt      = PHASE_FIRST;
                        start_pend_nxt = 1'b0;
                    end
                end
                ST_RUN: begin
                    if (div_cnt_r == ZERO_BYTE) begin
                        div_cnt_nxt  = div_r;
                        edge_ev      = 1'b1;
                        sclk_lvl_nxt = !sclk_lvl_r;
                        phase_nxt    = phase_r + 1'b1;
                        if (phase_r == PHASE_LAST) begin
                            if (ctrl_r.continuous_transfer_en && tx_valid) begin
                                load = 1'b1;
                            end else if (tx_valid && ctrl_r.transfer_trigger_sel) begin
                                state_nxt  = ST_GAP;
                                cs_act_nxt = 1'b0;
                            end else begin
                                state_nxt  = ST_IDLE;
                                cs_act_nxt = 1'b0;
                            end
                        end
                    end else begin
                        div_cnt_nxt = div_cnt_r - 1'b1;
                    end
                end
                ST_GAP: begin
                    if (div_cnt_r == ZERO_BYTE) begin
                        div_cnt_nxt = div_r;
                        phase_nxt   = phase_r + 1'b1;
                        if (phase_r[0]) begin
                            state_nxt = ST_IDLE;
                        end
                    end else begin
                        div_cnt_nxt = div_cnt_r - 1'b1;
                    end
                end
                default: state_nxt = ST_IDLE;
            endcase
        end else begin
            start_pend_nxt = 1'b0;
            cs_act_nxt     = !cs_s2;
            if (cs_s2) begin
                state_nxt = ST_IDLE;
                phase_nxt = PHASE_FIRST;
            end else if (state_r == ST_IDLE) begin
                load      = 1'b1;
                state_nxt = ST_RUN;
                phase_nxt = PHASE_FIRST;
            end else if (sclk_s2 != sclk_prev_r) begin
                edge_ev   = 1'b1;
                phase_nxt = phase_r + 1'b1;
                if (phase_r == PHASE_LAST) begin
                    load = 1'b1;
                end
            end
        end
    end

    // shift data path
    always_comb begin
        lead      = !phase_r[0];
        sample    = edge_ev && (lead ^ ctrl_r.clock_phase);
        shift     = edge_ev && !(lead ^ ctrl_r.clock_phase) && (phase_r != PHASE_FIRST);
        byte_done = edge_ev && (phase_r == PHASE_LAST);
        rx_ins    = ctrl_r.lsb_first_en ? {in_bit, rx_sh_r[DATA_W-1:1]}
                                        : {rx_sh_r[DATA_W-2:0], in_bit};
        rx_byte   = sample ? rx_ins : rx_sh_r;
        rx_sh_nxt = sample ? rx_ins : rx_sh_r;
        tx_sh_nxt = tx_sh_r;
        if (shift) begin
            tx_sh_nxt = ctrl_r.lsb_first_en ? {1'b0, tx_sh_r[DATA_W-1:1]}
                                            : {tx_sh_r[DATA_W-2:0], 1'b0};
        end
        tx_pop      = load && tx_valid;
        uf_set      = load && !tx_valid;
        load_byte   = tx_valid ? tx_head
                    : (ctrl_r.zero_fill_en ? ZERO_BYTE : last_tx_r);
        last_tx_nxt = last_tx_r;
        if (load) begin
            tx_sh_nxt   = load_byte;
            last_tx_nxt = load_byte;
        end
        out_bit_nxt = ctrl_r.lsb_first_en ? tx_sh_nxt[0] : tx_sh_nxt[DATA_W-1];
        // receive side with overflow policy
        ovf_set   = byte_done && !ctrl_r.rx_fifo_flush && rx_full;
        rx_push   = byte_done && !ctrl_r.rx_fifo_flush
                    && (!rx_full || ctrl_r.rx_overwrite_en);
        rx_pop    = (rx_rd && rx_valid) || (rx_push && rx_full);
        rxirq_set = rx_push && !ctrl_r.transfer_trigger_sel
                    && (rx_level >= LEVEL_W'(ctrl_r.irq_threshold_field));
        txirq_set = byte_done && ctrl_r.transfer_trigger_sel
                    && (tx_done_r == ctrl_r.irq_threshold_field);
        tx_done_nxt = tx_done_r;
        if (!ctrl_r.transfer_trigger_sel) begin
            tx_done_nxt = '0;
        end else if (byte_done) begin
            tx_done_nxt = txirq_set ? '0 : tx_done_r + 1'b1;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_r      <= ST_IDLE;
            div_cnt_r    <= DIV_RESET;
            phase_r      <= PHASE_FIRST;
            sclk_lvl_r   <= 1'b0;
            cs_act_r     <= 1'b0;
            start_pend_r <= 1'b0;
            tx_sh_r      <= ZERO_BYTE;
            rx_sh_r      <= ZERO_BYTE;
            last_tx_r    <= ZERO_BYTE;
            out_bit_r    <= 1'b0;
            tx_done_r    <= '0;
            sclk_pin_r   <= 1'b0;
        end else begin
            state_r      <= state_nxt;
            div_cnt_r    <= div_cnt_nxt;
            phase_r      <= phase_nxt;
            sclk_lvl_r   <= sclk_lvl_nxt;
            cs_act_r     <= cs_act_nxt;
            start_pend_r <= start_pend_nxt;
            tx_sh_r      <= tx_sh_nxt;
            rx_sh_r      <= rx_sh_nxt;
            last_tx_r    <= last_tx_nxt;
            out_bit_r    <= out_bit_nxt;
            tx_done_r    <= tx_done_nxt;
            sclk_pin_r   <= sclk_lvl_nxt ^ ctrl_r.clock_polarity;
        end
    end

    // registers, status flags and read data
    always_comb begin
        status                   = '0;
        status.rx_excess         = rx_level > (LEVEL_W'(ctrl_r.irq_threshold_field) + 1'b1);
        status.rx_level          = rx_level;
        status.rx_overflow_flag  = ovf_r;
        status.rx_irq            = rxirq_r;
        status.tx_irq            = txirq_r;
        status.tx_underflow_flag = uf_r;
        status.tx_level          = tx_level;
        status.irq_pending       = isr_r;
        ctrl_nxt = ctrl_r;
        div_nxt  = div_r;
        if (reg_wr_in && (reg_addr_in == CTRL_OFS)) begin
            ctrl_nxt = ctrl_s'(reg_wdata_in);
        end
        if (reg_wr_in && (reg_addr_in == DIV_OFS)) begin
            div_nxt = reg_wdata_in[DATA_W-1:0];
        end
        rdata_nxt = rdata_r;
        if (reg_rd_in) begin
            case (reg_addr_in)
                STATUS_OFS: rdata_nxt = status;
                RX_OFS:     rdata_nxt = CTRL_W'(rx_head);
                TX_OFS:     rdata_nxt = CTRL_W'(last_tx_r);
                DIV_OFS:    rdata_nxt = CTRL_W'(div_r);
                CTRL_OFS:   rdata_nxt = ctrl_r;
                default:    rdata_nxt = '0;
            endcase
        end
        // a status read clears, but an event in the same cycle wins
        ovf_nxt   = ovf_set   || (ovf_r   && !st_rd);
        uf_nxt    = uf_set    || (uf_r    && !st_rd);
        rxirq_nxt = rxirq_set || (rxirq_r && !st_rd);
        txirq_nxt = txirq_set || (txirq_r && !st_rd);
        isr_nxt   = rxirq_set || txirq_set
                    || (ovf_set && !ctrl_r.rx_fifo_flush)
                    || (uf_set && !ctrl_r.tx_fifo_flush)
                    || (isr_r && !st_rd);
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ctrl_r  <= ctrl_s'(CTRL_RESET);
            div_r   <= DIV_RESET;
            rdata_r <= '0;
            ovf_r   <= 1'b0;
            uf_r    <= 1'b0;
            rxirq_r <= 1'b0;
            txirq_r <= 1'b0;
            isr_r   <= 1'b0;
        end else begin
            ctrl_r  <= ctrl_nxt;
            div_r   <= div_nxt;
            rdata_r <= rdata_nxt;
            ovf_r   <= ovf_nxt;
            uf_r    <= uf_nxt;
            rxirq_r <= rxirq_nxt;
            txirq_r <= txirq_nxt;
            isr_r   <= isr_nxt;
        end
    end

    // pins
    assign od_mode               = ctrl_r.wired_or_output_en;
    assign reg_rdata_out         = rdata_r;
    assign irq_out               = isr_r;
    assign sclk_out              = sclk_pin_r;
    assign sclk_oe_out           = ctrl_r.port_enable && ctrl_r.master_select;
    assign mosi_out              = out_bit_r;
    assign mosi_oe_out           = ctrl_r.port_enable && ctrl_r.master_select
                                   && (!od_mode || !out_bit_r);
    assign miso_out              = out_bit_r;
    assign miso_oe_out           = ctrl_r.port_enable && !ctrl_r.master_select && !cs_s2
                                   && (!(od_mode || !ctrl_r.slave_miso_drive_en)
                                       || !out_bit_r);
    assign chip_select_pin_n_out = !(cs_act_r && ctrl_r.master_select);

endmodule : spi_port_control

`default_nettype wire

// ===== spi_port_props.sv
// spi_port_props: port checks of the serial port block
// assumes: bound into spi_port_control, control writes seen on the register port
`default_nettype none
module spi_port_props import spi_port_pkg::*; (
    input wire logic clk_in, rst_n_in, reg_wr_in, tx_space_out, sclk_out, sclk_oe_out,
    input wire logic mosi_out, mosi_oe_out, miso_out, miso_oe_out, chip_select_pin_n_out,
    input wire logic [ADDR_W-1:0] reg_addr_in,
    input wire logic [CTRL_W-1:0] reg_wdata_in
);
    ctrl_s c_r, c_nxt;
    logic [1:0] s_r, s_nxt;
    logic q, cs;
    always_comb begin
        c_nxt = (reg_wr_in && reg_addr_in == CTRL_OFS) ? ctrl_s'(reg_wdata_in) : c_r;
        s_nxt = (c_nxt != c_r) ? 2'h0 : s_r + {1'b0, s_r != 2'h3};
        q = s_r == 2'h3;
        cs = chip_select_pin_n_out;
    end
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin c_r <= '0; s_r <= '0; end
        else begin c_r <= c_nxt; s_r <= s_nxt; end
    end
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    property p_off; q && !c_r.port_enable |-> cs && !sclk_oe_out; endproperty
    a_off: assert property (p_off) else $error("active while off");
    property p_slv; q && !c_r.master_select |-> !sclk_oe_out; endproperty
    a_slv: assert property (p_slv) else $error("slave drives clock");
    property p_mst; q && c_r.master_select && c_r.port_enable |-> sclk_oe_out; endproperty
    a_mst: assert property (p_mst) else $error("master clock off");
    property p_rest; q && c_r.master_select && cs && $past(cs, 2)
        |-> sclk_out == c_r.clock_polarity; endproperty
    a_rest: assert property (p_rest) else $error("clock rest level");
    property p_frame; $fell(cs) |-> !cs [*8]; endproperty
    a_frame: assert property (p_frame) else $error("frame too short");
    property p_miso; q && !c_r.master_select && !c_r.slave_miso_drive_en
        |-> !(miso_oe_out && miso_out); endproperty
    a_miso: assert property (p_miso) else $error("miso driven high");
    property p_wor; q && c_r.wired_or_output_en |-> !(mosi_oe_out && mosi_out); endproperty
    a_wor: assert property (p_wor) else $error("mosi driven high");
    property p_flush; q && c_r.tx_fifo_flush |-> tx_space_out; endproperty
    a_flush: assert property (p_flush) else $error("flush holds data");
endmodule : spi_port_props
bind spi_port_control spi_port_props u_props (.*);
`default_nettype wire

// ===== spi_peer_model.sv
// spi_peer_model: serial slave at the far side of the port
// assumes: settled wires from the bench, the same reply byte for every byte of a frame
`default_nettype none
module spi_peer_model (
    input  wire logic       sclk, cs_n, mosi, cpol, cpha, lsb,
    input  wire logic [7:0] tx_byte,
    output logic            miso,
    output logic [7:0]      rx_byte,
    output int              n_rx
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] sh = 8'h00, acc = 8'h00;
    int n = 0;
    wire logic b = lsb ? sh[0] : sh[7];
    // pin values just before an edge that moves them too
    wire #1 cs_d = cs_n, md = mosi;
    assign miso = cs_n ? ~b : b;
    initial begin rx_byte = 8'h00; n_rx = 0; end
    always @(negedge cs_n) begin sh = tx_byte; n = 0; end
    always @(sclk) if (!cs_d) begin
        if ((sclk != cpol) ^ cpha) begin
            acc = lsb ? {md, acc[7:1]} : {acc[6:0], md};
            n++;
            if (n == 8) begin rx_byte = acc; n_rx++; n = 0; sh = tx_byte; end
        end else if (n > 0) sh = lsb ? sh >> 1 : sh << 1;
    end
endmodule : spi_peer_model
`default_nettype wire

// ===== tb.sv
// tb: register stimulus, peer model, byte queue model of the transfers
// assumes: master transfers at a 48 ns serial clock, slave pins idle
`default_nettype none
module tb;
    import spi_port_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_in = 1'b0, rst_n_in = 1'b0, reg_wr_in = 1'b0, reg_rd_in = 1'b0;
    logic [4:0] reg_addr_in = 5'h00;
    logic [15:0] reg_wdata_in = 16'h0000, reg_rdata_out, d;
    logic tx_space_out, irq_out, sclk_out, sclk_oe_out, mosi_out, mosi_oe_out, cs_n, miso;
    logic [7:0] pb, rx_byte, txq[$];
    int n_rx, mismatches = 0, n_tests = 0, seed = 14454;
    ctrl_s c = '0;
    spi_port_control u_dut (.clk_in, .rst_n_in, .reg_wr_in, .reg_rd_in, .reg_addr_in,
        .reg_wdata_in, .reg_rdata_out, .tx_space_out, .irq_out, .sclk_in(1'b0), .sclk_out,
        .sclk_oe_out, .mosi_in(1'b0), .mosi_out, .mosi_oe_out, .miso_in(miso), .miso_out(),
        .miso_oe_out(), .chip_select_pin_n_in(1'b1), .chip_select_pin_n_out(cs_n));
    spi_peer_model u_peer (.sclk(sclk_out), .cs_n(cs_n), .mosi(mosi_oe_out ? mosi_out : 1'b1),
        .cpol(c.clock_polarity), .cpha(c.clock_phase), .lsb(c.lsb_first_en), .tx_byte(pb),
        .miso(miso), .rx_byte(rx_byte), .n_rx(n_rx));
    initial forever #2 clk_in = ~clk_in;
    task automatic chk(input logic [15:0] got, exp);
        n_tests++;
        if (got !== exp) begin mismatches++; $display("[FAIL] %0t %h not %h", $time, got, exp); end
    endtask : chk
    task automatic acc(input logic w, input logic [4:0] a, input logic [15:0] v);
        reg_wr_in <= w; reg_rd_in <= !w; reg_addr_in <= a; reg_wdata_in <= v;
        @(posedge clk_in);
        reg_wr_in <= 1'b0; reg_rd_in <= 1'b0;
        @(posedge clk_in);
        d = reg_rdata_out;
    endtask : acc
    task automatic wait_rx();
        int n0;
        n0 = n_rx;
        for (int i = 0; i < 500 && n_rx == n0; i++) @(posedge clk_in);
        chk({7'h0, n_rx != n0, rx_byte}, {8'h01, txq.pop_front()});
    endtask : wait_rx
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : wrap_up
    initial begin
        repeat (20) @(posedge clk_in);
        rst_n_in <= 1'b1;
        @(posedge clk_in);
        acc(1'b0, CTRL_OFS, 16'h0); chk(d, CTRL_RESET);
        acc(1'b0, 5'h14, 16'h0); chk(d, 16'h0000);
        acc(1'b1, DIV_OFS, 16'h0005);
        for (int m = 0; m < 8; m++) begin
            c = '0; c.port_enable = 1'b1; c.master_select = 1'b1; c.transfer_trigger_sel = 1'b1;
            c.clock_polarity = m[0]; c.clock_phase = m[1]; c.lsb_first_en = m[2];
            c.continuous_transfer_en = m[0] ^ m[2];
            pb = 8'($random(seed));
            acc(1'b1, CTRL_OFS, 16'(c));
            repeat (2) begin txq.push_back(8'($random(seed))); acc(1'b1, TX_OFS, {8'h00, txq[$]}); end
            wait_rx(); wait_rx();
            repeat (20) @(posedge clk_in);
            chk({15'h0, irq_out}, 16'h0001);
            acc(1'b0, STATUS_OFS, 16'h0); chk({13'h0, d[10:8]}, 16'h0002);
            chk({13'h0, d[3:1]}, 16'h0000); chk({15'h0, d[5]}, 16'h0001);
            repeat (2) begin acc(1'b0, RX_OFS, 16'h0); chk({8'h00, d[7:0]}, {8'h00, pb}); end
            $display("mode %0d done", m);
        end
        c = '0; c.port_enable = 1'b1; c.tx_fifo_flush = 1'b1; c.wired_or_output_en = 1'b1;
        acc(1'b1, CTRL_OFS, 16'(c));
        acc(1'b1, TX_OFS, 16'h005a);
        acc(1'b0, STATUS_OFS, 16'h0); chk({13'h0, d[3:1]}, 16'h0000);
        acc(1'b0, CTRL_OFS, 16'h0); chk(d, 16'(c));
        $display("flush done");
        wrap_up();
    end
    initial begin repeat (20000) @(posedge clk_in); mismatches++; wrap_up(); end
endmodule : tb
`default_nettype wire
